// ---- core/tklm_loader.sv ----
// ***************************************************************
// tklm_loader: loader and monitor routines behind the teleprinter
// ***************************************************************
// holds the routine selector, record parser, store dump and store clear.
// assumes keyboard and tape characters come from logic on core_clk, the
// printer takes a character when tx_valid and tx_ready are both high, and
// the store returns rd_data one cycle after rd_addr is steady.
`timescale 1ns/10ps
module tklm_loader
    import tklm_pkg::*;
#(
    parameter logic [15:0] STORE_LAST = 16'h4095
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // interrupt push button pin
    input wire logic intr_button,
    // keyboard characters
    input wire tklm_char_s kbd_char,
    output logic kbd_ready,
    // tape reader characters
    input wire tklm_char_s tape_char,
    output logic tape_ready,
    // printer characters
    output logic tx_valid,
    output logic [5:0] tx_char,
    input wire logic tx_ready,
    // store ports
    output tklm_store_wr_s store_wr,
    output logic [15:0] rd_addr,
    input wire tklm_word_s rd_data
);

    typedef enum logic [3:0] {
        S_IDLE, S_CODE, S_ACK, S_LOAD, S_POUND, S_LOAD_END,
        S_RANGE, S_BLANK1, S_FETCH, S_DREC, S_BLANK2, S_CLEAR
    } tklm_state_e;

    // ***************************************************************
    // helpers
    // ***************************************************************

    // true for a decimal digit character
    function automatic logic is_digit(input logic [5:0] c);
        is_digit = (c[5:4] == CH_DIGIT_BASE[5:4]) && (c[3:0] <= 4'h9);
    endfunction

    // bcd increment of a four digit address
    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (carry)
            begin
                carry = (r[i*4 +: 4] == 4'h9);
                r[i*4 +: 4] = carry ? 4'h0 : r[i*4 +: 4] + 4'h1;
            end
        end
        bcd_inc = r;
    endfunction

    // digit character from a bcd nibble
    function automatic logic [5:0] dig(input logic [3:0] n);
        dig = {CH_DIGIT_BASE[5:4], n};
    endfunction

    // ***************************************************************
    // interrupt pin synchroniser
    // ***************************************************************

    logic [2:0] sync_q;
    logic btn_q;
    logic btn_d;
    logic intr_edge;

    // three stages; the level moves once stages two and three agree
    always_comb
    begin
        btn_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : btn_q;
        intr_edge = btn_d && !btn_q;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_q <= 3'h0;
            btn_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[1:0], intr_button};
            btn_q <= btn_d;
        end
    end

    // ***************************************************************
    // routine sequencer
    // ***************************************************************

    tklm_state_e state_q, state_d, ret_q, ret_d;
    logic [3:0] pos_q, pos_d;
    logic [5:0] cnt_q, cnt_d;
    logic [15:0] code_q, code_d, addr_q, addr_d, fin_q, fin_d;
    tklm_word_s word_q, word_d;
    logic skip_q, skip_d, tape_q, tape_d;
    logic [5:0] tx_q, tx_d;
    tklm_store_wr_s wr_q, wr_d;
    tklm_char_s rx;
    logic take;
    logic sent;

    // character due on the printer in a given state
    function automatic logic [5:0] out_char(input tklm_state_e st, input logic [3:0] p,
        input logic [15:0] a, input logic [15:0] f, input tklm_word_s w);
        out_char = CH_BLANK;
        case (st)
            S_ACK, S_LOAD_END: out_char = CH_LINE_FEED;
            S_POUND: out_char = CH_POUND;
            S_DREC:
            begin
                if (p < REC_GAP1)
                    out_char = dig(a[(3 - p[1:0])*4 +: 4]);
                else if (p == REC_GAP1 || p == REC_GAP2)
                    out_char = CH_GAP_CHAR;
                else if (p <= REC_FUNC_LO)
                    out_char = dig(p[0] ? w.func[7:4] : w.func[3:0]);
                else if (p <= REC_OPER_LO)
                    out_char = dig(w.oper[(REC_OPER_LO - p)*4 +: 4]);
                else if (p == REC_CR)
                    out_char = CH_CARRIAGE_RETURN;
                else
                    out_char = (a == f) ? CH_FIGURE_SHIFT : CH_LINE_FEED;
            end
            default: out_char = CH_BLANK;
        endcase
    endfunction

    // source handshakes; only the routine's own source is taken
    always_comb
    begin
        kbd_ready = (state_q == S_CODE) || (state_q == S_RANGE) ||
            ((state_q == S_LOAD) && !tape_q);
        tape_ready = (state_q == S_LOAD) && tape_q;
        rx = tape_q ? tape_char : kbd_char;
        if (state_q != S_LOAD)
            rx = kbd_char;
        take = rx.valid && (kbd_ready || tape_ready);
        tx_valid = (state_q == S_ACK) || (state_q == S_POUND) || (state_q == S_LOAD_END) ||
            (state_q == S_BLANK1) || (state_q == S_DREC) || (state_q == S_BLANK2);
        sent = tx_valid && tx_ready;
    end

    // next values of the sequencer
    always_comb
    begin
        state_d = state_q;
        ret_d = ret_q;
        pos_d = pos_q;
        cnt_d = cnt_q;
        code_d = code_q;
        addr_d = addr_q;
        fin_d = fin_q;
        word_d = word_q;
        skip_d = skip_q;
        tape_d = tape_q;
        wr_d = '0;
        case (state_q)
            S_IDLE: ;
            S_CODE:
            begin
                if (take && is_digit(rx.code))
                    code_d = {code_q[11:0], rx.code[3:0]};
                else if (take && rx.code == CH_CARRIAGE_RETURN)
                begin
                    code_d = RST_BCD16;
                    pos_d = RST_POS;
                    skip_d = 1'b0;
                    addr_d = RST_BCD16;
                    state_d = S_ACK;
                    case (code_q)
                        RT_TAPE_LOAD:
                        begin
                            ret_d = S_LOAD;
                            tape_d = 1'b1;
                        end
                        RT_KBD_LOAD:
                        begin
                            ret_d = S_LOAD;
                            tape_d = 1'b0;
                        end
                        RT_DUMP: ret_d = S_RANGE;
                        RT_CLEAR: ret_d = S_CLEAR;
                        default: state_d = S_CODE;
                    endcase
                end
                else if (take && rx.code != CH_BLANK)
                    code_d = RST_BCD16;
            end
            S_ACK:
            begin
                if (sent)
                begin
                    state_d = ret_q;
                    cnt_d = RST_CNT;
                end
            end
            S_LOAD:
            begin
                if (take && skip_q)
                begin
                    // resynchronise on the next record boundary
                    if (rx.code == CH_LINE_FEED)
                    begin
                        skip_d = 1'b0;
                        pos_d = RST_POS;
                    end
                    else if (rx.code == CH_FIGURE_SHIFT)
                        state_d = S_LOAD_END;
                end
                else if (take && !(pos_q == RST_POS && rx.code == CH_BLANK))
                begin
                    pos_d = pos_q + 4'h1;
                    if (pos_q < REC_GAP1 && is_digit(rx.code))
                        addr_d = {addr_q[11:0], rx.code[3:0]};
                    else if ((pos_q == REC_GAP1 || pos_q == REC_GAP2) &&
                        rx.code == CH_GAP_CHAR) ;
                    else if (pos_q > REC_GAP1 && pos_q <= REC_FUNC_LO && is_digit(rx.code))
                        word_d.func = {word_q.func[3:0], rx.code[3:0]};
                    else if (pos_q > REC_GAP2 && pos_q <= REC_OPER_LO && is_digit(rx.code))
                        word_d.oper = {word_q.oper[11:0], rx.code[3:0]};
                    else if (pos_q == REC_CR && rx.code == CH_CARRIAGE_RETURN) ;
                    else if (pos_q == REC_END &&
                        (rx.code == CH_LINE_FEED || rx.code == CH_FIGURE_SHIFT))
                    begin
                        wr_d = {1'b1, addr_q, word_q};
                        pos_d = RST_POS;
                        if (rx.code == CH_FIGURE_SHIFT)
                            state_d = S_LOAD_END;
                    end
                    else if (rx.code == CH_FIGURE_SHIFT)
                        state_d = S_LOAD_END;
                    else
                    begin
                        state_d = S_POUND;
                        ret_d = S_LOAD;
                        cnt_d = RST_CNT;
                        pos_d = RST_POS;
                        skip_d = (rx.code != CH_LINE_FEED);
                    end
                end
            end
            S_POUND:
            begin
                if (sent)
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == POUND_COUNT - 6'h01)
                        state_d = ret_q;
                end
            end
            S_LOAD_END:
            begin
                if (sent)
                    state_d = S_IDLE;
            end
            S_RANGE:
            begin
                if (take && !(pos_q == RST_POS && rx.code == CH_BLANK))
                begin
                    pos_d = pos_q + 4'h1;
                    if (pos_q < RNG_GAP1 && is_digit(rx.code))
                        addr_d = {addr_q[11:0], rx.code[3:0]};
                    else if ((pos_q == RNG_GAP1 || pos_q == RNG_GAP2) &&
                        rx.code == CH_GAP_CHAR) ;
                    else if (pos_q > RNG_GAP1 && pos_q < RNG_GAP2 && is_digit(rx.code))
                        fin_d = {fin_q[11:0], rx.code[3:0]};
                    else if (pos_q == RNG_CR && rx.code == CH_CARRIAGE_RETURN)
                    begin
                        state_d = S_ACK;
                        ret_d = S_BLANK1;
                    end
                    else
                    begin
                        state_d = S_POUND;
                        ret_d = S_RANGE;
                        cnt_d = RST_CNT;
                        pos_d = RST_POS;
                    end
                end
            end
            S_BLANK1, S_BLANK2:
            begin
                if (sent)
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == BLANK_FRAMES - 6'h01)
                    begin
                        state_d = (state_q == S_BLANK1) ? S_FETCH : S_IDLE;
                        cnt_d = RST_CNT;
                    end
                end
            end
            S_FETCH:
            begin
                cnt_d = cnt_q + 6'h01;
                if (cnt_q == READ_WAIT)
                begin
                    word_d = rd_data;
                    pos_d = RST_POS;
                    state_d = S_DREC;
                end
            end
            S_DREC:
            begin
                if (sent)
                begin
                    pos_d = pos_q + 4'h1;
                    if (pos_q == REC_END)
                    begin
                        cnt_d = RST_CNT;
                        if (addr_q == fin_q)
                            state_d = S_BLANK2;
                        else
                        begin
                            addr_d = bcd_inc(addr_q);
                            state_d = S_FETCH;
                        end
                    end
                end
            end
            S_CLEAR:
            begin
                wr_d = {1'b1, addr_q, 24'h000000};
                addr_d = bcd_inc(addr_q);
                if (addr_q == STORE_LAST)
                    state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
        // the button wins over every routine
        if (intr_edge)
        begin
            state_d = S_CODE;
            code_d = RST_BCD16;
            pos_d = RST_POS;
            skip_d = 1'b0;
            wr_d = '0;
        end
        tx_d = out_char(state_d, pos_d, addr_d, fin_d, word_d);
    end

    // sequencer registers
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= S_IDLE;
            ret_q <= S_IDLE;
            pos_q <= RST_POS;
            cnt_q <= RST_CNT;
            code_q <= RST_BCD16;
            addr_q <= RST_BCD16;
            fin_q <= RST_BCD16;
            word_q <= '0;
            skip_q <= 1'b0;
            tape_q <= 1'b0;
            tx_q <= CH_BLANK;
            wr_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            ret_q <= ret_d;
            pos_q <= pos_d;
            cnt_q <= cnt_d;
            code_q <= code_d;
            addr_q <= addr_d;
            fin_q <= fin_d;
            word_q <= word_d;
            skip_q <= skip_d;
            tape_q <= tape_d;
            tx_q <= tx_d;
            wr_q <= wr_d;
        end
    end

    // outputs from flops
    assign tx_char = tx_q;
    assign store_wr = wr_q;
    assign rd_addr = addr_q;

endmodule

// ---- core/tklm_pkg.sv ----
// ***************************************************************
// tklm_pkg: constants and types of the tape and keyboard loader
// ***************************************************************
// holds character codes, routine codes, record positions, counts and
// the packed carriers shared by the loader and its bench.
// assumes characters arrive already decoded into the six-bit code below.
package tklm_pkg;

    // six-bit character code; digits are 6'h10 to 6'h19
    localparam logic [5:0] CH_BLANK = 6'h00;
    localparam logic [5:0] CH_DIGIT_BASE = 6'h10;
    localparam logic [5:0] CH_GAP_CHAR = 6'h20;
    localparam logic [5:0] CH_CARRIAGE_RETURN = 6'h21;
    localparam logic [5:0] CH_LINE_FEED = 6'h22;
    localparam logic [5:0] CH_FIGURE_SHIFT = 6'h23;
    localparam logic [5:0] CH_POUND = 6'h24;

    // routine codes, four decimal digits held as bcd
    localparam logic [15:0] RT_TAPE_LOAD = 16'h0041;
    localparam logic [15:0] RT_KBD_LOAD = 16'h0051;
    localparam logic [15:0] RT_DUMP = 16'h0175;
    localparam logic [15:0] RT_CLEAR = 16'h0232;

    // character positions inside a load or dump record
    localparam logic [3:0] REC_GAP1 = 4'h4;
    localparam logic [3:0] REC_FUNC_LO = 4'h6;
    localparam logic [3:0] REC_GAP2 = 4'h7;
    localparam logic [3:0] REC_OPER_LO = 4'hb;
    localparam logic [3:0] REC_CR = 4'hc;
    localparam logic [3:0] REC_END = 4'hd;

    // character positions inside the dump range entry
    localparam logic [3:0] RNG_GAP1 = 4'h4;
    localparam logic [3:0] RNG_GAP2 = 4'h9;
    localparam logic [3:0] RNG_CR = 4'ha;

    // counts of emitted characters, and cycles of store read latency
    localparam logic [5:0] BLANK_FRAMES = 6'h3c;
    localparam logic [5:0] POUND_COUNT = 6'h03;
    localparam logic [5:0] READ_WAIT = 6'h01;

    // values after reset
    localparam logic [15:0] RST_BCD16 = 16'h0000;
    localparam logic [3:0] RST_POS = 4'h0;
    localparam logic [5:0] RST_CNT = 6'h00;

    // stored instruction: function then operand, all bcd
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] oper;
    } tklm_word_s;

    // one store write
    typedef struct packed {
        logic en;
        logic [15:0] addr;
        tklm_word_s data;
    } tklm_store_wr_s;

    // one character offered by a source
    typedef struct packed {
        logic valid;
        logic [5:0] code;
    } tklm_char_s;

endpackage

// ---- sim/tb_tklm_loader.sv ----
// ***************************************************************
// tb_tklm_loader: self-checking bench of the loader
// ***************************************************************
// drives keyboard, tape and button at falling edges, logs printed chars.
// assumes the teleprinter model for the store and printer.
`timescale 1ns/10ps
module tb_tklm_loader
    import tklm_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic intr_button = 1'b0;
    logic slow = 1'b0;
    tklm_char_s kbd_char = '0;
    tklm_char_s tape_char = '0;
    logic kbd_ready, tape_ready, tx_valid, tx_ready;
    logic [5:0] tx_char;
    tklm_store_wr_s store_wr;
    logic [15:0] rd_addr;
    tklm_word_s rd_data;
    logic [5:0] rx_q[$];
    logic [5:0] exp_q[$];
    int err_count = 0;
    int checks_done = 0;

    always #50 core_clk = ~core_clk;

    tklm_loader #(.STORE_LAST(16'h0003)) dut_u (.core_clk(core_clk), .resetn(resetn),
        .intr_button(intr_button), .kbd_char(kbd_char), .kbd_ready(kbd_ready),
        .tape_char(tape_char), .tape_ready(tape_ready), .tx_valid(tx_valid),
        .tx_char(tx_char), .tx_ready(tx_ready), .store_wr(store_wr), .rd_addr(rd_addr),
        .rd_data(rd_data));
    tklm_teleprinter p_u (.core_clk(core_clk), .resetn(resetn), .slow(slow),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .store_wr(store_wr), .rd_addr(rd_addr),
        .rd_data(rd_data));

    // log every char the printer takes
    always @(posedge core_clk)
        if (tx_valid && tx_ready)
            rx_q.push_back(tx_char);

    // ***************************************************************
    // helpers
    // ***************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // offer one char, hold it until the loader takes it
    task automatic put(input bit tp, input logic [5:0] c);
        int n;
        n = 0;
        if (tp) tape_char = '{1'b1, c};
        else kbd_char = '{1'b1, c};
        while (!(tp ? tape_ready : kbd_ready) && n < 3000)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(n < 3000, 1'b1);
        @(negedge core_clk);
    endtask

    task automatic idle();
        kbd_char = '0;
        tape_char = '0;
    endtask

    task automatic put_num(input bit tp, input logic [15:0] v, input int nd);
        for (int i = nd - 1; i >= 0; i--) put(tp, CH_DIGIT_BASE + v[i*4+:4]);
    endtask

    task automatic put_rec(input bit tp, input logic [15:0] a, input logic [7:0] f,
        input logic [15:0] o, input bit last);
        put_num(tp, a, 4);
        put(tp, CH_GAP_CHAR);
        put_num(tp, {8'h00, f}, 2);
        put(tp, CH_GAP_CHAR);
        put_num(tp, o, 4);
        put(tp, CH_CARRIAGE_RETURN);
        put(tp, last ? CH_FIGURE_SHIFT : CH_LINE_FEED);
        idle();
    endtask

    task automatic e_num(input logic [15:0] v, input int nd);
        for (int i = nd - 1; i >= 0; i--) exp_q.push_back(CH_DIGIT_BASE + v[i*4+:4]);
    endtask

    task automatic e_rec(input logic [15:0] a, input logic [7:0] f, input logic [15:0] o,
        input bit last);
        e_num(a, 4);
        exp_q.push_back(CH_GAP_CHAR);
        e_num({8'h00, f}, 2);
        exp_q.push_back(CH_GAP_CHAR);
        e_num(o, 4);
        exp_q.push_back(CH_CARRIAGE_RETURN);
        exp_q.push_back(last ? CH_FIGURE_SHIFT : CH_LINE_FEED);
    endtask

    // wait for the expected printout, then compare it char by char
    task automatic expect_out();
        int n;
        n = 0;
        while (rx_q.size() < exp_q.size() && n < 5000)
        begin
            @(negedge core_clk);
            n++;
        end
        repeat (20) @(negedge core_clk);
        chk(rx_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(i < rx_q.size() ? rx_q[i] : 6'h3f, exp_q[i]);
        rx_q = {};
        exp_q = {};
    endtask

    task automatic press();
        intr_button = 1'b1;
        repeat (10) @(negedge core_clk);
        intr_button = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    // press, type a routine code and return, expect one line feed
    task automatic enter(input logic [15:0] code);
        press();
        put_num(1'b0, code, 4);
        put(1'b0, CH_CARRIAGE_RETURN);
        idle();
        exp_q.push_back(CH_LINE_FEED);
        expect_out();
    endtask

    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic sc_unknown_then_kbd();
        press();
        put_num(1'b0, 16'h0099, 4);
        put(1'b0, CH_CARRIAGE_RETURN);
        idle();
        expect_out();
        put_num(1'b0, RT_KBD_LOAD, 4);
        put(1'b0, CH_CARRIAGE_RETURN);
        idle();
        exp_q.push_back(CH_LINE_FEED);
        expect_out();
        put_rec(1'b0, 16'h0002, 8'h12, 16'h0345, 1'b0);
        put(1'b0, CH_DIGIT_BASE);
        put(1'b0, CH_GAP_CHAR);
        put(1'b0, CH_LINE_FEED);
        put_rec(1'b0, 16'h0003, 8'h07, 16'h0008, 1'b1);
        repeat (3) exp_q.push_back(CH_POUND);
        exp_q.push_back(CH_LINE_FEED);
        expect_out();
        chk(p_u.mem[16'h0002], {8'h12, 16'h0345});
        chk(p_u.mem[16'h0003], {8'h07, 16'h0008});
        $display("keyboard load done");
    endtask

    task automatic sc_tape();
        enter(RT_TAPE_LOAD);
        repeat (5) put(1'b1, CH_BLANK);
        put(1'b1, CH_GAP_CHAR);
        put(1'b1, CH_LINE_FEED);
        put_rec(1'b1, 16'h0001, 8'h34, 16'h5678, 1'b1);
        repeat (3) exp_q.push_back(CH_POUND);
        exp_q.push_back(CH_LINE_FEED);
        expect_out();
        chk(p_u.mem[16'h0001], {8'h34, 16'h5678});
        enter(RT_TAPE_LOAD);
        put_num(1'b1, 16'h0000, 2);
        idle();
        press();
        chk({kbd_ready, tape_ready}, 2'b10);
        chk(p_u.mem.exists(16'h0000), 1'b0);
        $display("tape load done");
    endtask

    task automatic sc_dump();
        slow = 1'b1;
        enter(RT_DUMP);
        put_num(1'b0, 16'h0001, 4);
        put(1'b0, CH_GAP_CHAR);
        put_num(1'b0, 16'h0002, 4);
        put(1'b0, CH_GAP_CHAR);
        put(1'b0, CH_CARRIAGE_RETURN);
        idle();
        exp_q.push_back(CH_LINE_FEED);
        repeat (60) exp_q.push_back(CH_BLANK);
        e_rec(16'h0001, 8'h34, 16'h5678, 1'b0);
        e_rec(16'h0002, 8'h12, 16'h0345, 1'b1);
        repeat (60) exp_q.push_back(CH_BLANK);
        expect_out();
        slow = 1'b0;
        $display("dump done");
    endtask

    task automatic sc_clear();
        enter(RT_CLEAR);
        repeat (20) @(negedge core_clk);
        for (int a = 0; a < 4; a++) chk(p_u.mem[a[15:0]], 24'h0);
        $display("clear done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog well past the expected run
    initial
    begin
        #6000000;
        err_count++;
        finish_test();
    end

    // main sequence
    initial
    begin
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        sc_unknown_then_kbd();
        sc_tape();
        sc_dump();
        sc_clear();
        finish_test();
    end
endmodule

// ---- sim/tklm_loader_checker.sv ----
// ***************************************************************
// tklm_loader_checker: port assertions of the loader
// ***************************************************************
// watches the ports of tklm_loader only.
// assumes one clock domain and the bind at the foot.
`timescale 1ns/10ps
module tklm_loader_checker
    import tklm_pkg::*;
#(
    parameter logic [15:0] STORE_LAST = 16'h4095
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic intr_button,
    input wire tklm_char_s kbd_char,
    input wire logic kbd_ready,
    input wire tklm_char_s tape_char,
    input wire logic tape_ready,
    input wire logic tx_valid,
    input wire logic [5:0] tx_char,
    input wire logic tx_ready,
    input wire tklm_store_wr_s store_wr,
    input wire logic [15:0] rd_addr,
    input wire tklm_word_s rd_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // true when every nibble is a decimal digit
    function automatic logic is_bcd(input logic [15:0] v);
        return v[15:12] <= 4'h9 && v[11:8] <= 4'h9 && v[7:4] <= 4'h9 && v[3:0] <= 4'h9;
    endfunction

    tx_hold_a: assert property (disable iff (!resetn || intr_button)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
        else $error("printer char dropped or changed before taken");
    wr_bcd_a: assert property (store_wr.en |-> is_bcd(store_wr.addr))
        else $error("store write address not decimal");
    rd_bcd_a: assert property (tx_valid |-> is_bcd(rd_addr))
        else $error("dump address not decimal");
    clear_zero_a: assert property (
        store_wr.en && $past(store_wr.en) |-> store_wr.data == '0)
        else $error("clear wrote nonzero data");
    intr_abandon_a: assert property (
        $rose(intr_button) |-> ##[1:8] (kbd_ready && !tape_ready))
        else $error("interrupt did not return to code entry");
    char_legal_a: assert property (tx_valid |-> (tx_char == CH_BLANK)
        || (tx_char >= CH_DIGIT_BASE && tx_char <= 6'h19)
        || (tx_char >= CH_GAP_CHAR && tx_char <= CH_POUND))
        else $error("illegal printer char");
    cr_silent_a: assert property (
        kbd_char.valid && kbd_ready && kbd_char.code == CH_CARRIAGE_RETURN
        ##1 !tx_valid |-> kbd_ready)
        else $error("silent return left keyboard entry");
    tape_only_a: assert property (tape_ready |-> !kbd_ready)
        else $error("tape and keyboard ready together");
endmodule

bind tklm_loader tklm_loader_checker #(.STORE_LAST(STORE_LAST)) chk_u (.core_clk(core_clk),
    .resetn(resetn), .intr_button(intr_button), .kbd_char(kbd_char), .kbd_ready(kbd_ready),
    .tape_char(tape_char), .tape_ready(tape_ready), .tx_valid(tx_valid), .tx_char(tx_char),
    .tx_ready(tx_ready), .store_wr(store_wr), .rd_addr(rd_addr), .rd_data(rd_data));

// ---- sim/tklm_teleprinter.sv ----
// ***************************************************************
// tklm_teleprinter: printer and store model for the loader bench
// ***************************************************************
// holds the store as a sparse map and a printer that may stall.
// assumes the loader drives store_wr and rd_addr on core_clk.
`timescale 1ns/10ps
module tklm_teleprinter
    import tklm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // printer side
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    // store side
    input wire tklm_store_wr_s store_wr,
    input wire logic [15:0] rd_addr,
    output tklm_word_s rd_data
);
    tklm_word_s mem [logic [15:0]];
    logic [1:0] pace_q;

    // store: write on en, read one cycle after the address
    always @(posedge core_clk)
    begin
        if (store_wr.en)
            mem[store_wr.addr] = store_wr.data;
        rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : '0;
    end

    // printer takes one char in four when slow, else every cycle
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pace_q <= 2'h0;
        else
            pace_q <= pace_q + 2'h1;
    end
    assign tx_ready = slow ? (pace_q == 2'h3) : 1'b1;
endmodule
